/* File: rtl/pad_enable_mux.sv */
// Selects each covered pad's output enable between GPIO direction and serial function.
`timescale 1ns/10ps
module pad_enable_mux #(
  parameter int PINS = 7
) (
  input  wire logic [PINS-1:0] gpio_select,
  input  wire logic [PINS-1:0] direction,
  input  wire logic [PINS-1:0] serial_output_enable,
  output logic      [PINS-1:0] pad_output_enable
);
  // A pin still serving its serial port ignores its direction bit.
  assign pad_output_enable = (gpio_select & direction) |
                             (~gpio_select & serial_output_enable);
endmodule

/* File: rtl/serial_pin_gpio_direction_bits.sv */
// Direction register bits 13 to 7 for serial pins reassigned to general purpose I/O.
//
// Overview of operation
// - Bit 13 directs port 3 transmit pin.
// - Bit 12 directs port 3 request-to-send pin.
// - Bit 11 directs port 2 receive pin.
// - Bit 10 directs port 2 clear-to-send pin.
// - Bit 9 directs port 2 transmit pin.
// - Bit 8 directs port 2 request-to-send pin.
// - Bit 7 directs port 1 receive pin.
// - Direction bit ignored while pin stays serial.
`timescale 1ns/10ps
`include "serial_pin_gpio_params.svh"
module serial_pin_gpio_direction_bits #(
  parameter int PINS   = 7,
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  input  wire logic [6:0]  serial_output_enable,
  output logic      [6:0]  pad_output_enable
);

  // Pin order in every 7-bit vector except dir_low: index 0 is port1_receive_pin (bit 7)
  // up to index 6, port3_transmit_pin (bit 13).

  // A write lands at the edge that samples its strobe; a read answers one
  // cycle later and the answer stands for that cycle only, so the bus never
  // has to wait and back-to-back strobes need no gap.
  // The pad enables trail the registers by one more cycle.

  // Reset is synchronous: every flop below clears on the first edge that
  // sees it, and the pads come out of reset as inputs.

  localparam logic [DATA_W-1:0] RDATA_IDLE = 32'h0000_0000;

  // True when the bus address selects the given register.
  function automatic logic addr_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] offset
  );
    return addr == offset;
  endfunction

  // One bit of a bus word, picked by its field position.
  function automatic logic word_bit(
    input serial_pin_gpio_pkg::reg_word_t word,
    input int unsigned                    pos
  );
    return word[pos];
  endfunction

  // Bits 6 to 0 of a bus word.
  function automatic serial_pin_gpio_pkg::pin_vec_t low_field(
    input serial_pin_gpio_pkg::reg_word_t word
  );
    return word[6:0];
  endfunction

  // Bits 15 and 14 of a bus word.
  function automatic logic [1:0] high_field(
    input serial_pin_gpio_pkg::reg_word_t word
  );
    return word[15:14];
  endfunction

  // Direction word as software reads it; bits 31 to 16 are reserved and read zero.
  function automatic serial_pin_gpio_pkg::reg_word_t dir_word(
    input logic [1:0]                    high,
    input serial_pin_gpio_pkg::pin_vec_t mid,
    input serial_pin_gpio_pkg::pin_vec_t low
  );
    return {16'h0000, high, mid, low};
  endfunction

  logic                           dir_port3_transmit;
  logic                           dir_port3_request_to_send;
  logic                           dir_port2_receive;
  logic                           dir_port2_clear_to_send;
  logic                           dir_port2_transmit;
  logic                           dir_port2_request_to_send;
  logic                           dir_port1_receive;

  // Bits 15, 14 and 6 to 0 are kept as plain storage so software sees the
  // whole word, although they steer no pad in this block.
  logic [1:0]                     dir_high;
  serial_pin_gpio_pkg::pin_vec_t  dir_low;
  serial_pin_gpio_pkg::pin_vec_t  gpio_select;
  serial_pin_gpio_pkg::pin_vec_t  next_pad_oe;

  // One enable flop per pad, so each pad is driven straight from a flop.
  logic                           pad_oe_port3_transmit;
  logic                           pad_oe_port3_request_to_send;
  logic                           pad_oe_port2_receive;
  logic                           pad_oe_port2_clear_to_send;
  logic                           pad_oe_port2_transmit;
  logic                           pad_oe_port2_request_to_send;
  logic                           pad_oe_port1_receive;

  wire logic hit_dir   = addr_hit(reg_addr, `DIR_REG_OFFSET);
  wire logic hit_sel   = addr_hit(reg_addr, `SEL_REG_OFFSET);
  wire logic write_dir = reg_write && hit_dir;
  wire logic write_sel = reg_write && hit_sel;

  // Pin vector in index order, port1_receive_pin in the lowest place.
  wire serial_pin_gpio_pkg::pin_vec_t direction = {
    dir_port3_transmit,
    dir_port3_request_to_send,
    dir_port2_receive,
    dir_port2_clear_to_send,
    dir_port2_transmit,
    dir_port2_request_to_send,
    dir_port1_receive
  };

  // Unmapped addresses read as zero; reserved upper bits read as zero.
  wire serial_pin_gpio_pkg::reg_word_t dir_readback = dir_word(dir_high, direction, dir_low);
  wire serial_pin_gpio_pkg::reg_word_t sel_readback = {25'h000_0000, gpio_select};
  wire serial_pin_gpio_pkg::reg_word_t read_mux =
    hit_dir ? dir_readback :
    hit_sel ? sel_readback : RDATA_IDLE;

  // Port 3 transmit pin: a one makes it drive while it serves as GPIO.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dir_port3_transmit <= word_bit(`DIR_REG_RESET, `PORT3_TX_BIT);
    end else if (write_dir) begin
      dir_port3_transmit <= word_bit(reg_wdata, `PORT3_TX_BIT);
    end
  end

  // Port 3 request-to-send pin.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dir_port3_request_to_send <= word_bit(`DIR_REG_RESET, `PORT3_RTS_BIT);
    end else if (write_dir) begin
      dir_port3_request_to_send <= word_bit(reg_wdata, `PORT3_RTS_BIT);
    end
  end

  // Port 2 receive pin.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dir_port2_receive <= word_bit(`DIR_REG_RESET, `PORT2_RX_BIT);
    end else if (write_dir) begin
      dir_port2_receive <= word_bit(reg_wdata, `PORT2_RX_BIT);
    end
  end

  // Port 2 clear-to-send pin.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dir_port2_clear_to_send <= word_bit(`DIR_REG_RESET, `PORT2_CTS_BIT);
    end else if (write_dir) begin
      dir_port2_clear_to_send <= word_bit(reg_wdata, `PORT2_CTS_BIT);
    end
  end

  // Port 2 transmit pin.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dir_port2_transmit <= word_bit(`DIR_REG_RESET, `PORT2_TX_BIT);
    end else if (write_dir) begin
      dir_port2_transmit <= word_bit(reg_wdata, `PORT2_TX_BIT);
    end
  end

  // Port 2 request-to-send pin.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dir_port2_request_to_send <= word_bit(`DIR_REG_RESET, `PORT2_RTS_BIT);
    end else if (write_dir) begin
      dir_port2_request_to_send <= word_bit(reg_wdata, `PORT2_RTS_BIT);
    end
  end

  // Port 1 receive pin.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dir_port1_receive <= word_bit(`DIR_REG_RESET, `PORT1_RX_BIT);
    end else if (write_dir) begin
      dir_port1_receive <= word_bit(reg_wdata, `PORT1_RX_BIT);
    end
  end

  // Upper stored bits, outside this slice of the register.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dir_high <= high_field(`DIR_REG_RESET);
    end else if (write_dir) begin
      dir_high <= high_field(reg_wdata);
    end
  end

  // Lower stored bits, outside this slice of the register.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dir_low <= low_field(`DIR_REG_RESET);
    end else if (write_dir) begin
      dir_low <= low_field(reg_wdata);
    end
  end

  // GPIO select, one bit per covered pin in index order.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      gpio_select <= `SEL_REG_RESET;
    end else if (write_sel) begin
      gpio_select <= low_field(reg_wdata);
    end
  end

  // Read data are zero outside the answer cycle, so a stray sample sees nothing.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reg_rdata <= RDATA_IDLE;
    end else begin
      reg_rdata <= reg_read ? read_mux : RDATA_IDLE;
    end
  end

  pad_enable_mux #(.PINS(PINS)) u_mux (
    .gpio_select          (gpio_select),
    .direction            (direction),
    .serial_output_enable (serial_output_enable),
    .pad_output_enable    (next_pad_oe)
  );

  // Registered so the pads see a clean edge-aligned enable; this costs one
  // cycle of latency from the serial function's own enable.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pad_oe_port3_transmit <= 1'h0;
    end else begin
      pad_oe_port3_transmit <= next_pad_oe[6];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pad_oe_port3_request_to_send <= 1'h0;
    end else begin
      pad_oe_port3_request_to_send <= next_pad_oe[5];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pad_oe_port2_receive <= 1'h0;
    end else begin
      pad_oe_port2_receive <= next_pad_oe[4];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pad_oe_port2_clear_to_send <= 1'h0;
    end else begin
      pad_oe_port2_clear_to_send <= next_pad_oe[3];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pad_oe_port2_transmit <= 1'h0;
    end else begin
      pad_oe_port2_transmit <= next_pad_oe[2];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pad_oe_port2_request_to_send <= 1'h0;
    end else begin
      pad_oe_port2_request_to_send <= next_pad_oe[1];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pad_oe_port1_receive <= 1'h0;
    end else begin
      pad_oe_port1_receive <= next_pad_oe[0];
    end
  end

  // Plain wiring of the flops above, in index order.
  assign pad_output_enable = {
    pad_oe_port3_transmit,
    pad_oe_port3_request_to_send,
    pad_oe_port2_receive,
    pad_oe_port2_clear_to_send,
    pad_oe_port2_transmit,
    pad_oe_port2_request_to_send,
    pad_oe_port1_receive
  };

endmodule

/* File: rtl/serial_pin_gpio_params.svh */
// Offsets, field positions and reset values of the serial pin direction register.
`ifndef SERIAL_PIN_GPIO_PARAMS_SVH
`define SERIAL_PIN_GPIO_PARAMS_SVH

`define DIR_REG_OFFSET      8'h88
`define SEL_REG_OFFSET      8'h90
`define DIR_REG_RESET       32'h0000_0000
`define SEL_REG_RESET       7'h00
`define DIR_FIELD_LSB       7
`define DIR_FIELD_MSB       13
`define DIR_REG_RW_MASK     32'h0000_FFFF
`define PORT3_TX_BIT        13
`define PORT3_RTS_BIT       12
`define PORT2_RX_BIT        11
`define PORT2_CTS_BIT       10
`define PORT2_TX_BIT        9
`define PORT2_RTS_BIT       8
`define PORT1_RX_BIT        7

`endif

/* File: rtl/serial_pin_gpio_pkg.sv */
// Types shared by the serial pin direction block.
package serial_pin_gpio_pkg;
  typedef logic [31:0] reg_word_t;
  typedef logic [6:0]  pin_vec_t;
endpackage

/* File: tb/dir_sva.sv */
// Assertions on the serial pin direction block.
`timescale 1ns/10ps
module dir_sva (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic [6:0]  serial_output_enable,
  input wire logic [6:0]  pad_output_enable
);
  logic [6:0] model_sel;
  logic [6:0] model_dir;
  // Expected register contents, kept from the bus traffic alone.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      model_sel <= 7'h00;
      model_dir <= 7'h00;
    end else begin
      if (reg_write && reg_addr == 8'h90) model_sel <= reg_wdata[6:0];
      if (reg_write && reg_addr == 8'h88) model_dir <= reg_wdata[13:7];
    end
  end
  sequence s_dir_write;
    reg_write && reg_addr == 8'h88;
  endsequence
  sequence s_dir_read;
    reg_read && reg_addr == 8'h88;
  endsequence
  sequence s_other_read;
    reg_read && reg_addr != 8'h88 && reg_addr != 8'h90;
  endsequence
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 0) else $error("rdata not idle");
  a_upper_zero: assert property (reg_rdata[31:16] == 0) else $error("upper bits set");
  a_dir_readback: assert property (s_dir_write ##1 !reg_write ##1 s_dir_read |=>
    reg_rdata[15:0] == $past(reg_wdata[15:0], 3)) else $error("dir readback wrong");
  a_unmapped_zero: assert property (s_other_read |=> reg_rdata == 0) else $error("unmapped read");
  a_pad_reset: assert property ($past(sys_rst) |-> pad_output_enable == 0) else $error("pad reset");
  a_pad_serial: assert property (!$past(sys_rst) |-> (pad_output_enable & ~$past(model_sel)) ==
    ($past(serial_output_enable) & ~$past(model_sel))) else $error("serial pad wrong");
  a_pad_gpio: assert property (!$past(sys_rst) |-> (pad_output_enable & $past(model_sel)) ==
    ($past(model_dir) & $past(model_sel))) else $error("gpio pad wrong");
endmodule
bind serial_pin_gpio_direction_bits dir_sva chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .serial_output_enable(serial_output_enable),
  .pad_output_enable(pad_output_enable));

/* File: tb/tb.sv */
// Self-checking bench for the serial pin direction bits.
`timescale 1ns/10ps
module tb;
  logic clk_sys = 0, sys_rst = 1, reg_write = 0, reg_read = 0;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [6:0] soe = 0, pad;
  int mismatches = 0, total_checks = 0;
  serial_pin_gpio_direction_bits dut_u (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .serial_output_enable(soe), .pad_output_enable(pad));
  initial forever #12.5 clk_sys = ~clk_sys;
  task chk(string n, logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin mismatches++; $display("unexpected %s exp %h seen %h", n, e, s); end
  endtask
  task wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys) begin reg_addr <= a; reg_wdata <= d; reg_write <= 1; end
    @(posedge clk_sys) reg_write <= 0;
  endtask
  task rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk_sys) begin reg_addr <= a; reg_read <= 1; end
    @(posedge clk_sys) reg_read <= 0;
    #1 chk("rdata", reg_rdata, e);
  endtask
  task pad_is(logic [6:0] e);
    repeat (2) @(posedge clk_sys);
    #1 chk("pad", {25'h0, pad}, {25'h0, e});
  endtask
  task t_regs;
    rd(8'h88, 32'h0000_0000);
    wr(8'h88, 32'hFFFF_FFFF);
    rd(8'h88, 32'h0000_FFFF);
    rd(8'h04, 32'h0000_0000);
    $display("t_regs done");
  endtask
  task t_pad;
    @(posedge clk_sys) soe <= 7'h55;
    pad_is(7'h55);
    wr(8'h90, 32'h0000_007F);
    pad_is(7'h7F);
    wr(8'h88, 32'h0000_1500);
    wr(8'h90, 32'h0000_000F);
    pad_is(7'h5A);
    $display("t_pad done");
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 0;
    t_regs;
    t_pad;
    complete_run;
  end
endmodule
